// File: inc/compact_isa_params.svh
// constants for the compact instruction-state decoder
`ifndef COMPACT_ISA_PARAMS_SVH
`define COMPACT_ISA_PARAMS_SVH

// ============================================================
// addresses and steps
`define ISA_RESET_PC        32'h0000_0000
`define ISA_HALF_STEP       32'h0000_0002
`define ISA_WORD_STEP       32'h0000_0004

// ============================================================
// condition codes
`define ISA_COND_ALWAYS     4'he
`define ISA_COND_NONE       4'hf

// ============================================================
// first-halfword field patterns
`define ISA_LONG_TOP_A      5'h1d
`define ISA_LONG_TOP_B      5'h1e
`define ISA_LONG_TOP_C      5'h1f
`define ISA_IT_TOP          8'hbf
`define ISA_CZB_TOP         4'hb
`define ISA_CONDBR_TOP      4'hd
`define ISA_BOUNDS_TOP      8'hca
`define ISA_HANDLER_TOP     5'h18
`define ISA_MEM_FIRST       4'h5
`define ISA_MEM_LAST        4'h9
`define ISA_LONG_MEM_TOP    7'h7c

// ============================================================
// environment enter/leave pair
`define ISA_STCHG_HW1       16'hf3bf
`define ISA_STCHG_HW2_TOP   12'h8f1

// ============================================================
// predication block
`define ISA_IT_MAX_LEN      3'h4

`endif

// File: inc/compact_isa_pkg.sv
// types for the compact instruction-state decoder
package compact_isa_pkg;

    // decode state selected by the two status bits
    typedef enum logic [1:0] {
        MODE_STANDARD = 2'h0,
        MODE_COMPACT  = 2'h1,
        MODE_VARIANT  = 2'h3
    } isa_mode_type;

    // coarse instruction class handed to execute
    typedef enum logic [3:0] {
        CLS_PLAIN        = 4'h0,
        CLS_IF_THEN      = 4'h1,
        CLS_CZB          = 4'h2,
        CLS_COND_BRANCH  = 4'h3,
        CLS_HANDLER      = 4'h4,
        CLS_BOUNDS       = 4'h5,
        CLS_STATE_CHANGE = 4'h6,
        CLS_MEMORY       = 4'h7
    } instr_class_type;

    // fetch sequencer states, one-hot
    typedef enum logic [2:0] {
        FS_START  = 3'b001,
        FS_FIRST  = 3'b010,
        FS_SECOND = 3'b100
    } fetch_state_type;

    // request to the fetch unit
    typedef struct packed {
        logic [31:0] addr;
        logic        word;
    } fetch_req_type;

    // decoded instruction to execute
    typedef struct packed {
        isa_mode_type    mode;
        logic            is_32bit;
        instr_class_type cls;
        logic            conditional;
        logic            null_check;
        logic [3:0]      cond;
        logic [31:0]     addr;
        logic [31:0]     instr;
    } decoded_type;

endpackage

// File: src/halfword_classifier.sv
// first-halfword length and class decoder
`timescale 1ns/1ps
`default_nettype none
`include "compact_isa_params.svh"

module halfword_classifier (
    // halfword under test
    input  wire logic                             [15:0] first_halfword,
    input  wire logic                                    variant_mode,
    // classification
    output logic                                         is_long,
    output compact_isa_pkg::instr_class_type             cls,
    output logic                                         null_check
);
    import compact_isa_pkg::*;

    // ============================================================
    // length: 32-bit forms live in the old long-branch-link space
    always_comb begin
        is_long = (first_halfword[15:11] == `ISA_LONG_TOP_A) ||
                  (first_halfword[15:11] == `ISA_LONG_TOP_B) ||
                  (first_halfword[15:11] == `ISA_LONG_TOP_C);
    end

    // ============================================================
    // class from the first halfword alone
    always_comb begin
        cls        = CLS_PLAIN;
        null_check = 1'b0;
        if (is_long) begin
            // 32-bit loads and stores get base checks in the variant
            if (variant_mode && first_halfword[15:9] == `ISA_LONG_MEM_TOP) begin
                cls        = CLS_MEMORY;
                null_check = 1'b1;
            end
        end else if (first_halfword[15:8] == `ISA_IT_TOP && first_halfword[3:0] != 4'h0) begin
            cls = CLS_IF_THEN;
        end else if (first_halfword[15:12] == `ISA_CZB_TOP && !first_halfword[10]
                     && first_halfword[8]) begin
            cls = CLS_CZB;
        end else if (first_halfword[15:12] == `ISA_CONDBR_TOP
                     && first_halfword[11:8] < `ISA_COND_ALWAYS) begin
            cls = CLS_COND_BRANCH;
        end else if (variant_mode && first_halfword[15:8] == `ISA_BOUNDS_TOP) begin
            cls = CLS_BOUNDS;
        end else if (variant_mode && first_halfword[15:11] == `ISA_HANDLER_TOP) begin
            cls = CLS_HANDLER;
        end else if (first_halfword[15:12] >= `ISA_MEM_FIRST
                     && first_halfword[15:12] <= `ISA_MEM_LAST) begin
            cls = CLS_MEMORY;
            null_check = variant_mode;
        end
    end

endmodule // halfword_classifier
`default_nettype wire

// File: src/compact_isa_state_decoder.sv
// instruction-state selection and front-end decode for the compact set
`timescale 1ns/1ps
`default_nettype none
`include "compact_isa_params.svh"

module compact_isa_state_decoder #(
    parameter logic [31:0] RESET_PC = `ISA_RESET_PC
) (
    // clock and reset
    input  wire logic                             core_clk,
    input  wire logic                             resetn,
    // program status register state bits
    input  wire logic                             ps_compact_bit,
    input  wire logic                             ps_extended_bit,
    // redirect from execute
    input  wire logic                             redirect_valid,
    input  wire logic                      [31:0] redirect_addr,
    // fetch request and response
    output logic                                  fetch_req_valid,
    output compact_isa_pkg::fetch_req_type        fetch_req,
    input  wire logic                             fetch_rsp_valid,
    input  wire logic                      [31:0] fetch_rsp_data,
    // decoded stream to execute
    output logic                                  dec_valid,
    output compact_isa_pkg::decoded_type          dec,
    output logic                            [7:0] if_then_state
);
    import compact_isa_pkg::*;

    // ============================================================
    // mode decode, used by the sequencer and the issue path
    function automatic isa_mode_type isa_mode_of(input logic compact_bit,
                                                 input logic extended_bit);
        if (compact_bit && !extended_bit) begin
            return MODE_COMPACT;
        end else if (compact_bit && extended_bit) begin
            return MODE_VARIANT;
        end else begin
            return MODE_STANDARD;
        end
    endfunction

    // ============================================================
    // state
    fetch_state_type state_reg;       // sequencer state
    fetch_state_type state_next;      // its next value
    logic [31:0]     pc_reg;          // address of next instruction
    logic [31:0]     pc_next;         // its next value
    logic            drop_reg;        // stale response still owed
    logic [15:0]     hold_hw_reg;     // first halfword of a long form
    isa_mode_type    hold_mode_reg;   // mode seen at the first halfword
    logic [7:0]      itstate_reg;     // base condition and block mask
    logic [2:0]      blk_count_reg;   // instructions issued in a block
    logic            req_valid_reg;   // request strobe
    fetch_req_type   req_reg;         // request payload
    logic            dec_valid_reg;   // issue strobe
    decoded_type     dec_reg;         // issued instruction

    // ============================================================
    // combinational helpers
    isa_mode_type    mode_now;        // mode from live status bits
    logic            rsp_take;        // response that belongs to us
    logic            first_long;      // first halfword is a long form
    instr_class_type first_cls;       // class of the first halfword
    logic            first_null;      // base check wanted
    logic            issue;           // send a request this cycle
    logic [31:0]     issue_addr;      // where to fetch
    logic            issue_word;      // whole word or halfword
    logic            emit;            // hand an instruction to execute
    logic            emit_long;       // it is a 32-bit form
    logic [31:0]     emit_instr;      // its bits
    instr_class_type emit_cls;        // its class
    logic            emit_null;       // its base check
    isa_mode_type    emit_mode;       // its decode state
    logic            in_block;        // inside a predication block

    assign mode_now = isa_mode_of(ps_compact_bit, ps_extended_bit);
    // stale answers after a redirect are swallowed here
    assign rsp_take = fetch_rsp_valid && !drop_reg;
    assign in_block = (itstate_reg[3:0] != 4'h0);

    // ============================================================
    // classify the low halfword of the answer
    halfword_classifier u_classify (
        .first_halfword (fetch_rsp_data[15:0]),
        .variant_mode   (mode_now == MODE_VARIANT),
        .is_long        (first_long),
        .cls            (first_cls),
        .null_check     (first_null)
    );

    // ============================================================
    // sequencer next state, fetch issue and instruction emit
    always_comb begin
        state_next = state_reg;
        pc_next    = pc_reg;
        issue      = 1'b0;
        issue_addr = pc_reg;
        issue_word = (mode_now == MODE_STANDARD);
        emit       = 1'b0;
        emit_long  = 1'b0;
        emit_instr = fetch_rsp_data;
        emit_cls   = first_cls;
        emit_null  = first_null;
        emit_mode  = mode_now;
        case (state_reg)
            FS_START: begin
                // redirect here just moves the start point
                if (redirect_valid) begin
                    pc_next = redirect_addr;
                end else begin
                    issue      = 1'b1;
                    state_next = FS_FIRST;
                end
            end
            FS_FIRST: begin
                if (redirect_valid) begin
                    pc_next    = redirect_addr;
                    state_next = FS_START;
                end else if (rsp_take && mode_now == MODE_STANDARD) begin
                    emit       = 1'b1;
                    emit_long  = 1'b1;
                    emit_cls   = CLS_PLAIN;
                    emit_null  = 1'b0;
                    pc_next    = pc_reg + `ISA_WORD_STEP;
                    issue      = 1'b1;
                    issue_addr = pc_next;
                end else if (rsp_take && first_long) begin
                    issue      = 1'b1;
                    issue_addr = pc_reg + `ISA_HALF_STEP;
                    issue_word = 1'b0;
                    state_next = FS_SECOND;
                end else if (rsp_take) begin
                    emit       = 1'b1;
                    emit_instr = {16'h0000, fetch_rsp_data[15:0]};
                    pc_next    = pc_reg + `ISA_HALF_STEP;
                    issue      = 1'b1;
                    issue_addr = pc_next;
                end
            end
            FS_SECOND: begin
                emit_mode  = hold_mode_reg;
                emit_instr = {hold_hw_reg, fetch_rsp_data[15:0]};
                emit_cls   = CLS_PLAIN;
                emit_null  = 1'b0;
                if (redirect_valid) begin
                    pc_next    = redirect_addr;
                    state_next = FS_START;
                end else if (rsp_take) begin
                    emit       = 1'b1;
                    emit_long  = 1'b1;
                    pc_next    = pc_reg + `ISA_WORD_STEP;
                    issue      = 1'b1;
                    issue_addr = pc_next;
                    issue_word = 1'b0;
                    state_next = FS_FIRST;
                    if (hold_hw_reg == `ISA_STCHG_HW1
                        && fetch_rsp_data[15:4] == `ISA_STCHG_HW2_TOP) begin
                        emit_cls = CLS_STATE_CHANGE;
                    end else if (hold_mode_reg == MODE_VARIANT
                                 && hold_hw_reg[15:9] == `ISA_LONG_MEM_TOP) begin
                        emit_cls  = CLS_MEMORY;
                        emit_null = 1'b1;
                    end
                end
            end
            default: begin
                state_next = FS_START;
            end
        endcase
    end

    // ============================================================
    // sequencer state and program counter
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_reg <= FS_START;
            pc_reg    <= RESET_PC;
        end else begin
            state_reg <= state_next;
            pc_reg    <= pc_next;
        end
    end

    // ============================================================
    // stale-response tracking; fetch answers strictly in order
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            drop_reg <= 1'b0;
        end else if (redirect_valid && state_reg != FS_START && !fetch_rsp_valid) begin
            // request outstanding with no answer yet: owe one drop
            drop_reg <= 1'b1;
        end else if (fetch_rsp_valid) begin
            drop_reg <= 1'b0;
        end
    end

    // ============================================================
    // first halfword and its mode kept across the second fetch
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            hold_hw_reg   <= 16'h0000;
            hold_mode_reg <= MODE_STANDARD;
        end else if (state_reg == FS_FIRST && rsp_take) begin
            hold_hw_reg   <= fetch_rsp_data[15:0];
            hold_mode_reg <= mode_now;
        end
    end

    // ============================================================
    // fetch request register
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            req_valid_reg <= 1'b0;
            req_reg       <= '0;
        end else begin
            req_valid_reg <= issue;
            if (issue) begin
                req_reg.addr <= issue_addr;
                req_reg.word <= issue_word;
            end
        end
    end

    // ============================================================
    // predication block state, advanced per issued instruction
    always_ff @(posedge core_clk) begin
        if (!resetn || redirect_valid) begin
            // a taken branch always leaves the block
            itstate_reg   <= 8'h00;
            blk_count_reg <= 3'h0;
        end else if (emit && emit_mode != MODE_STANDARD) begin
            if (emit_cls == CLS_IF_THEN && !emit_long && !in_block) begin
                itstate_reg   <= emit_instr[7:0];
                blk_count_reg <= 3'h0;
            end else if (in_block) begin
                if (itstate_reg[2:0] == 3'h0) begin
                    itstate_reg <= 8'h00;
                end else begin
                    itstate_reg <= {itstate_reg[7:5], itstate_reg[3:0], 1'b0};
                end
                blk_count_reg <= blk_count_reg + 3'h1;
            end
        end
    end

    // ============================================================
    // issue register towards execute
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            dec_valid_reg <= 1'b0;
            dec_reg       <= '0;
        end else begin
            dec_valid_reg <= emit;
            if (emit) begin
                dec_reg.mode       <= emit_mode;
                dec_reg.is_32bit   <= emit_long;
                dec_reg.cls        <= emit_cls;
                dec_reg.null_check <= emit_null;
                dec_reg.addr       <= pc_reg;
                dec_reg.instr      <= emit_instr;
                if (emit_mode == MODE_STANDARD) begin
                    // standard words carry their own condition field
                    dec_reg.cond        <= emit_instr[31:28];
                    dec_reg.conditional <= (emit_instr[31:28] != `ISA_COND_ALWAYS);
                end else if (in_block) begin
                    dec_reg.cond        <= itstate_reg[7:4];
                    dec_reg.conditional <= 1'b1;
                end else if (emit_cls == CLS_COND_BRANCH && !emit_long) begin
                    dec_reg.cond        <= emit_instr[11:8];
                    dec_reg.conditional <= 1'b1;
                end else begin
                    dec_reg.cond        <= `ISA_COND_ALWAYS;
                    dec_reg.conditional <= 1'b0;
                end
            end
        end
    end

    assign fetch_req_valid = req_valid_reg;
    assign fetch_req       = req_reg;
    assign dec_valid       = dec_valid_reg;
    assign dec             = dec_reg;
    assign if_then_state   = itstate_reg;

    // ============================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_take_long;
        state_reg == FS_FIRST && rsp_take && !redirect_valid
            && mode_now != MODE_STANDARD && first_long;
    endsequence
    sequence s_take_short;
        state_reg == FS_FIRST && rsp_take && !redirect_valid
            && mode_now != MODE_STANDARD && !first_long;
    endsequence

    AST_SECOND_AT_PLUS_TWO: assert property (
        s_take_long |=> fetch_req_valid && !fetch_req.word && state_reg == FS_SECOND
            && fetch_req.addr == $past(pc_reg) + `ISA_HALF_STEP)
        else $error("second halfword not fetched at plus two");
    AST_STANDARD_WORDS: assert property (
        dec_valid && dec.mode == MODE_STANDARD |-> dec.is_32bit
            && $past(state_reg) == FS_FIRST)
        else $error("standard state issued a non-word");
    AST_COMPACT_SELECT: assert property (
        s_take_short and (ps_compact_bit && !ps_extended_bit)
            |=> dec_valid && dec.mode == MODE_COMPACT && !dec.is_32bit)
        else $error("compact state not decoded");
    AST_VARIANT_SELECT: assert property (
        s_take_short and (ps_compact_bit && ps_extended_bit)
            |=> dec_valid && dec.mode == MODE_VARIANT)
        else $error("variant state not decoded");
    AST_VARIANT_ONLY: assert property (
        dec_valid && dec.mode != MODE_VARIANT |-> !dec.null_check
            && dec.cls != CLS_HANDLER && dec.cls != CLS_BOUNDS)
        else $error("variant-only instruction outside variant state");
    AST_BLOCK_LENGTH: assert property (
        blk_count_reg <= `ISA_IT_MAX_LEN)
        else $error("predication block longer than four");
    AST_BLOCK_OPENS: assert property (
        dec_valid && dec.cls == CLS_IF_THEN && $past(!in_block) && !$past(redirect_valid)
            |-> if_then_state == dec.instr[7:0])
        else $error("prefix did not open a block");
    AST_LONG_UNCOND: assert property (
        dec_valid && dec.is_32bit && dec.mode != MODE_STANDARD && !$past(in_block)
            |-> !dec.conditional && dec.cond == `ISA_COND_ALWAYS)
        else $error("long form made conditional outside a block");
    AST_CZB_CLASS: assert property (
        s_take_short and (fetch_rsp_data[15:12] == `ISA_CZB_TOP && !fetch_rsp_data[10]
            && fetch_rsp_data[8]) |=> dec_valid && dec.cls == CLS_CZB)
        else $error("compare zero branch not recognised");
    AST_MIXED_STEP: assert property (
        s_take_short |=> fetch_req_valid && !fetch_req.word
            && fetch_req.addr == $past(pc_reg) + `ISA_HALF_STEP)
        else $error("short form did not step by two");

endmodule // compact_isa_state_decoder
`default_nettype wire

// File: dv/fetch_model.sv
// fetch unit model answering the decoder's requests from a small memory
`timescale 1ns/1ps
`default_nettype none

module fetch_model (
    // clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           resetn,
    // request side
    input  wire logic                           req_valid,
    input  wire compact_isa_pkg::fetch_req_type req,
    input  wire logic [1:0]                     rsp_delay,
    // answer side
    output logic                                rsp_valid,
    output logic [31:0]                         rsp_data
);
    import compact_isa_pkg::*;
    // ============================================================
    // state
    logic [15:0]   mem [0:15];      // halfword store, loaded by bench
    fetch_req_type queue [0:3];     // requests in flight, oldest first
    logic [1:0]    wr_ptr;          // next free slot
    logic [1:0]    rd_ptr;          // oldest request
    logic [1:0]    wait_cnt;        // cycles the oldest has waited
    fetch_req_type head;            // oldest request
    assign head = queue[rd_ptr];
    // ============================================================
    // one answer per request, in order, never in the request's own cycle;
    // a redirect leaves a stale request in flight, so requests queue
    always_ff @(posedge core_clk) begin
        rsp_valid <= 1'b0;
        // data off an answer is junk so stale values never match
        rsp_data <= ~rsp_data;
        if (!resetn) begin
            rsp_data <= 32'h0000_0000;
            wr_ptr   <= 2'h0;
            rd_ptr   <= 2'h0;
            wait_cnt <= 2'h0;
        end else begin
            if (req_valid) begin
                queue[wr_ptr] <= req;
                wr_ptr        <= wr_ptr + 2'h1;
            end
            if (rd_ptr != wr_ptr && wait_cnt < rsp_delay) begin
                wait_cnt <= wait_cnt + 2'h1;
            end else if (rd_ptr != wr_ptr) begin
                wait_cnt  <= 2'h0;
                rd_ptr    <= rd_ptr + 2'h1;
                rsp_valid <= 1'b1;
                rsp_data  <= {head.word ? mem[head.addr[4:1] + 4'h1] : 16'h0000,
                              mem[head.addr[4:1]]};
            end
        end
    end
endmodule // fetch_model
`default_nettype wire

// File: dv/test_compact_isa_state_decoder.sv
// self-checking bench for the compact instruction-state decoder
`timescale 1ns/1ps
`default_nettype none

module test_compact_isa_state_decoder;
    import compact_isa_pkg::*;
    // ============================================================
    // stimulus and observed signals
    logic core_clk = 1'b0, resetn = 1'b0, redirect_valid = 1'b0;
    logic ps_compact_bit = 1'b0, ps_extended_bit = 1'b0;
    logic [31:0] redirect_addr = 32'h0000_0000, fetch_rsp_data;
    logic [1:0] rsp_delay = 2'h0;
    logic fetch_req_valid, fetch_rsp_valid, dec_valid;
    logic [7:0] if_then_state;
    fetch_req_type fetch_req;
    decoded_type dec;
    int errors = 0, samples_checked = 0;
    initial forever #2.5 core_clk = ~core_clk;

    compact_isa_state_decoder compact_isa_state_decoder_inst (.core_clk(core_clk),
        .resetn(resetn), .ps_compact_bit(ps_compact_bit), .ps_extended_bit(ps_extended_bit),
        .redirect_valid(redirect_valid), .redirect_addr(redirect_addr),
        .fetch_req_valid(fetch_req_valid), .fetch_req(fetch_req),
        .fetch_rsp_valid(fetch_rsp_valid), .fetch_rsp_data(fetch_rsp_data),
        .dec_valid(dec_valid), .dec(dec), .if_then_state(if_then_state));
    fetch_model fetch_model_inst (.core_clk(core_clk), .resetn(resetn),
        .req_valid(fetch_req_valid), .req(fetch_req), .rsp_delay(rsp_delay),
        .rsp_valid(fetch_rsp_valid), .rsp_data(fetch_rsp_data));

    // ============================================================
    // comparison and closing
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // restart the stream at zero in the given state
    task automatic start(input logic cb, input logic eb, input logic [1:0] dly);
        @(posedge core_clk);
        ps_compact_bit <= cb;
        ps_extended_bit <= eb;
        rsp_delay <= dly;
        redirect_valid <= 1'b1;
        @(posedge core_clk);
        redirect_valid <= 1'b0;
    endtask
    // wait, bounded, for the next issue and compare its fields
    task automatic next_dec(input logic [31:0] a, input logic l, input instr_class_type c,
                            input logic cd, input isa_mode_type m);
        int n;
        n = 0;
        @(negedge core_clk);
        while (dec_valid !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 40) begin
            errors++;
            final_report();
        end
        check("addr", dec.addr, a);
        check("is_32bit", dec.is_32bit, l);
        check("cls", dec.cls, c);
        check("conditional", dec.conditional, cd);
        check("mode", dec.mode, m);
    endtask

    // ============================================================
    // scenarios
    task automatic compact_mix();  // slow fetch, short-long-short
        fetch_model_inst.mem[0:3] = '{16'h2001, 16'hf000, 16'hf800, 16'h2002};
        start(1'b1, 1'b0, 2'h2);
        next_dec(32'h0, 1'b0, CLS_PLAIN, 1'b0, MODE_COMPACT);
        next_dec(32'h2, 1'b1, CLS_PLAIN, 1'b0, MODE_COMPACT);
        check("long_instr", dec.instr, 32'hf000_f800);
        next_dec(32'h6, 1'b0, CLS_PLAIN, 1'b0, MODE_COMPACT);
    endtask
    task automatic prefix_block();  // one-instruction block, then compare-zero-branch
        fetch_model_inst.mem[0:3] = '{16'hbf08, 16'h2001, 16'h2002, 16'hb100};
        start(1'b1, 1'b0, 2'h0);
        next_dec(32'h0, 1'b0, CLS_IF_THEN, 1'b0, MODE_COMPACT);
        check("it_state", if_then_state, 8'h08);
        next_dec(32'h2, 1'b0, CLS_PLAIN, 1'b1, MODE_COMPACT);
        check("cond", dec.cond, 4'h0);
        next_dec(32'h4, 1'b0, CLS_PLAIN, 1'b0, MODE_COMPACT);
        next_dec(32'h6, 1'b0, CLS_CZB, 1'b0, MODE_COMPACT);
    endtask
    task automatic variant_only();  // same code in variant then compact state
        fetch_model_inst.mem[0:4] = '{16'hca00, 16'hc000, 16'h6800, 16'hf3bf, 16'h8f10};
        for (int v = 1; v >= 0; v--) begin
            start(1'b1, v[0], 2'h1);
            next_dec(32'h0, 1'b0, v ? CLS_BOUNDS : CLS_PLAIN, 1'b0,
                     v ? MODE_VARIANT : MODE_COMPACT);
            next_dec(32'h2, 1'b0, v ? CLS_HANDLER : CLS_PLAIN, 1'b0,
                     v ? MODE_VARIANT : MODE_COMPACT);
            next_dec(32'h4, 1'b0, CLS_MEMORY, 1'b0, v ? MODE_VARIANT : MODE_COMPACT);
            check("null_check", dec.null_check, v[0]);
            next_dec(32'h6, 1'b1, CLS_STATE_CHANGE, 1'b0,
                     v ? MODE_VARIANT : MODE_COMPACT);
        end
    endtask
    task automatic standard_words();  // compact bit low: whole words only
        fetch_model_inst.mem[0:3] = '{16'h0000, 16'he000, 16'h0000, 16'h1000};
        start(1'b0, 1'b0, 2'h0);
        next_dec(32'h0, 1'b1, CLS_PLAIN, 1'b0, MODE_STANDARD);
        check("std_instr", dec.instr, 32'he000_0000);
        check("word_fetch", fetch_req.word, 1'b1);
        next_dec(32'h4, 1'b1, CLS_PLAIN, 1'b1, MODE_STANDARD);
    endtask

    // ============================================================
    // main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        compact_mix();
        prefix_block();
        variant_only();
        standard_words();
        final_report();
    end
endmodule // test_compact_isa_state_decoder
`default_nettype wire
